// *** include/edbs_pkg.sv ***
package edbs_pkg;
  // ==========================================================
  // stretch field and cycle counts
  // ==========================================================
  localparam int          STRETCH_W        = 3;
  localparam logic [2:0]  STRETCH_RESET    = 3'h1;
  localparam logic [2:0]  STRETCH_WIDE     = 3'h4;
  localparam int          MCYC_W           = 4;
  localparam int          UNIT_W           = 11;
  localparam logic [10:0] UNIT_DIV3        = 11'h400;
  localparam logic [10:0] UNIT_DIV2        = 11'h004;
  localparam logic [10:0] UNIT_X2          = 11'h002;
  localparam logic [10:0] UNIT_X4          = 11'h001;
  localparam logic [1:0]  DIV_SEL_DIV3     = 2'h3;
  localparam logic [1:0]  DIV_SEL_DIV2     = 2'h2;
  // ==========================================================
  // carriers
  // ==========================================================
  typedef struct packed {
    logic        write;
    logic        internal;
    logic [23:0] addr;
    logic [7:0]  wdata;
  } edbs_req_s;

  typedef struct packed {
    logic [23:0] addr;
    logic [7:0]  dataOut;
    logic        dataOe;
    logic        addrLatch;
    logic        readStrobe_n;
    logic        writeStrobe_n;
  } edbs_bus_s;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_ALE    = 6'b000010,
    ST_SETUP  = 6'b000100,
    ST_STROBE = 6'b001000,
    ST_HOLD   = 6'b010000,
    ST_DONE   = 6'b100000
  } edbs_state_e;
endpackage

// *** rtl/edbs_timing.sv ***
// per-stretch phase lengths in machine cycles
module edbs_timing (
  input  wire logic [2:0]  stretch,
  output logic      [3:0]  totalCycles,
  output logic      [3:0]  aleCycles,
  output logic      [3:0]  setupCycles,
  output logic      [3:0]  strobeCycles,
  output logic      [3:0]  holdCycles
);
  logic wide;
  always_comb begin
    wide = (stretch >= edbs_pkg::STRETCH_WIDE);
    // address latch: 1, plus one at wide settings
    aleCycles    = wide ? 4'h2 : 4'h1; // RL9
    // setup cycle added from stretch 1
    setupCycles  = (stretch != 3'h0) ? 4'h1 : 4'h0; // RL7
    // strobe: 1 at stretch 0 and 1, then one more per step, one more at wide
    strobeCycles = (stretch == 3'h0) ? 4'h1 : // RL8 RL11 RL13
                   ({1'b0, stretch} + (wide ? 4'h1 : 4'h0));
    // hold: the extra address and data cycle at wide only
    holdCycles   = wide ? 4'h1 : 4'h0; // RL10 RL12 RL13
    // total: 2,3,4,5,9,10,11,12
    totalCycles  = wide ? (4'h5 + {1'b0, stretch}) : (4'h2 + {1'b0, stretch}); // RL3
  end
endmodule

// *** rtl/edbs_ctrl.sv ***
// ==========================================================
// external data bus stretch controller
// ==========================================================
// Behaviour
// [RL1] stretch 0..7 from clock control field
// [RL2] stretch 0 two, stretch 7 twelve
// [RL3] totals 2,3,4,5,9,10,11,12 machine cycles
// [RL4] on-chip moves always two cycles
// [RL5] program fetches never stretched
// [RL6] stretch resets to one
// [RL7] stretch one adds setup and hold
// [RL8] stretch 2,3 widen strobe each
// [RL9] wide settings lengthen address latch
// [RL10] wide settings hold address one more
// [RL11] wide settings widen strobe one more
// [RL12] wide settings hold write data longer
// [RL13] above four only strobe grows
// [RL14] new stretch accepted any time
// [RL15] strobe width stretch times clock unit
// [RL16] far party finishes within strobe window
// [RL17] stretch sampled at move start
// [RL18] unit from multiplier and divider selects
module edbs_ctrl #(
  parameter int UNIT_MAX = 1024
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic                 stretchWrite,
  input  wire logic [2:0]           stretchSelectField,
  input  wire logic                 clockMultiplierSelect,
  input  wire logic [1:0]           clockDividerSelect,
  input  wire logic                 machineTick,
  input  wire logic                 moveStart,
  input  wire edbs_pkg::edbs_req_s  moveReq,
  input  wire logic [7:0]           busDataIn,
  output logic [2:0]                stretchValue,
  output logic [10:0]               clockUnit,
  output logic                      moveBusy,
  output logic                      moveDone,
  output logic [7:0]                readData,
  output edbs_pkg::edbs_bus_s       bus
);
  // ==========================================================
  // stretch register
  // ==========================================================
  logic [2:0] stretch_q, stretch_d;
  always_comb begin
    stretch_d = stretch_q;
    if (stretchWrite) begin
      stretch_d = stretchSelectField; // RL1 RL14
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stretch_q <= edbs_pkg::STRETCH_RESET; // RL6
    end else begin
      stretch_q <= stretch_d;
    end
  end
  assign stretchValue = stretch_q;

  // ==========================================================
  // clock unit
  // ==========================================================
  // clock unit in oscillator clocks for strobe width
  always_comb begin
    if (clockDividerSelect == edbs_pkg::DIV_SEL_DIV3) begin // RL15 RL18
      clockUnit = edbs_pkg::UNIT_DIV3;
    end else if (clockDividerSelect == edbs_pkg::DIV_SEL_DIV2) begin
      clockUnit = edbs_pkg::UNIT_DIV2;
    end else if (clockMultiplierSelect) begin
      clockUnit = edbs_pkg::UNIT_X4;
    end else begin
      clockUnit = edbs_pkg::UNIT_X2;
    end
  end

  // ==========================================================
  // bus cycle sequencer
  // ==========================================================
  edbs_pkg::edbs_state_e state_q, state_d;
  logic [2:0]            cur_q, cur_d;
  logic [3:0]            cnt_q, cnt_d;
  logic [3:0]            ela_q, ela_d;
  edbs_pkg::edbs_req_s   req_q, req_d;
  logic [7:0]            rdat_q, rdat_d;
  logic [3:0]            totC, aleC, setC, strC, hldC;

  edbs_timing u_timing (
    .stretch      (cur_q),
    .totalCycles  (totC),
    .aleCycles    (aleC),
    .setupCycles  (setC),
    .strobeCycles (strC),
    .holdCycles   (hldC)
  );

  always_comb begin
    state_d = state_q;
    cur_d   = cur_q;
    cnt_d   = cnt_q;
    req_d   = req_q;
    rdat_d  = rdat_q;
    ela_d   = ela_q;
    unique case (state_q)
      edbs_pkg::ST_IDLE: begin
        if (moveStart) begin
          req_d   = moveReq;
          // latch now so mid-cycle writes do not matter
          cur_d   = moveReq.internal ? 3'h0 : stretch_q; // RL4 RL5 RL17
          ela_d   = 4'h0;
          cnt_d   = 4'h0;
          state_d = edbs_pkg::ST_ALE;
        end
      end
      edbs_pkg::ST_ALE: begin
        if (machineTick) begin
          cnt_d = cnt_q + 4'h1;
          if (cnt_q + 4'h1 >= aleC) begin // RL9
            cnt_d   = 4'h0;
            state_d = (setC != 4'h0) ? edbs_pkg::ST_SETUP : edbs_pkg::ST_STROBE;
          end
        end
      end
      edbs_pkg::ST_SETUP: begin
        if (machineTick) begin
          state_d = edbs_pkg::ST_STROBE; // RL7
        end
      end
      edbs_pkg::ST_STROBE: begin
        if (machineTick) begin
          cnt_d = cnt_q + 4'h1;
          if (cnt_q + 4'h1 >= strC) begin // RL8 RL11 RL13 RL16
            cnt_d   = 4'h0;
            rdat_d  = busDataIn;
            state_d = (hldC != 4'h0) ? edbs_pkg::ST_HOLD : edbs_pkg::ST_DONE;
          end
        end
      end
      edbs_pkg::ST_HOLD: begin
        if (machineTick) begin
          cnt_d = cnt_q + 4'h1;
          if (cnt_q + 4'h1 >= hldC) begin // RL10 RL12
            cnt_d   = 4'h0;
            state_d = edbs_pkg::ST_DONE;
          end
        end
      end
      edbs_pkg::ST_DONE: begin
        state_d = edbs_pkg::ST_IDLE;
      end
      default: begin
        state_d = edbs_pkg::ST_IDLE;
      end
    endcase
    // overall cycle count caps the move
    if (state_q != edbs_pkg::ST_IDLE && state_q != edbs_pkg::ST_DONE && machineTick) begin
      ela_d = ela_q + 4'h1;
      if (ela_q + 4'h1 >= totC) begin // RL2 RL3
        cnt_d   = 4'h0;
        state_d = edbs_pkg::ST_DONE;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= edbs_pkg::ST_IDLE;
      cur_q   <= 3'h0;
      cnt_q   <= 4'h0;
      req_q   <= '0;
      rdat_q  <= 8'h00;
      ela_q   <= 4'h0;
    end else begin
      state_q <= state_d;
      cur_q   <= cur_d;
      cnt_q   <= cnt_d;
      req_q   <= req_d;
      rdat_q  <= rdat_d;
      ela_q   <= ela_d;
    end
  end

  // ==========================================================
  // external pins, registered
  // ==========================================================
  edbs_pkg::edbs_bus_s bus_q, bus_d;
  logic                done_q, done_d;
  logic                ext;
  always_comb begin
    ext                 = !req_d.internal;
    bus_d               = '0;
    bus_d.readStrobe_n  = 1'b1;
    bus_d.writeStrobe_n = 1'b1;
    done_d              = (state_d == edbs_pkg::ST_DONE);
    if (ext && state_d != edbs_pkg::ST_IDLE && state_d != edbs_pkg::ST_DONE) begin
      bus_d.addr      = req_d.addr;
      bus_d.addrLatch = (state_d == edbs_pkg::ST_ALE);
      if (state_d == edbs_pkg::ST_STROBE) begin
        bus_d.readStrobe_n  = req_d.write;
        bus_d.writeStrobe_n = !req_d.write;
      end
      if (req_d.write && state_d != edbs_pkg::ST_ALE) begin
        bus_d.dataOut = req_d.wdata; // RL12
        bus_d.dataOe  = 1'b1;
      end
    end
    // write data kept through the done clock from stretch 1
    if (ext && state_d == edbs_pkg::ST_DONE && req_d.write && cur_d != 3'h0) begin // RL7
      bus_d.addr    = req_d.addr;
      bus_d.dataOut = req_d.wdata;
      bus_d.dataOe  = 1'b1;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_q  <= '{default: '0, readStrobe_n: 1'b1, writeStrobe_n: 1'b1};
      done_q <= 1'b0;
    end else begin
      bus_q  <= bus_d;
      done_q <= done_d;
    end
  end

  assign bus      = bus_q;
  assign moveDone = done_q; // RL2 RL3
  assign moveBusy = (state_q != edbs_pkg::ST_IDLE);
  assign readData = rdat_q;
endmodule

// *** tb/edbs_mem_model.sv ***
module edbs_mem_model (
  input  wire logic                sys_clk,
  input  wire edbs_pkg::edbs_bus_s bus,
  output logic [7:0]               busDataIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  logic [7:0] lastQ = 8'h00;
  always @(posedge sys_clk) begin
    if (!bus.writeStrobe_n) mem[bus.addr[7:0]] <= bus.dataOut;
    if (!bus.readStrobe_n) lastQ <= mem[bus.addr[7:0]];
  end
  // released bus shows inverse of last byte
  assign busDataIn = !bus.readStrobe_n ? mem[bus.addr[7:0]] : ~lastQ;
endmodule

// *** tb/edbs_ctrl_assertions.sv ***
module edbs_ctrl_assertions (
  input wire logic                sys_clk,
  input wire logic                rst_n,
  input wire logic                stretchWrite,
  input wire logic [2:0]          stretchSelectField,
  input wire logic                clockMultiplierSelect,
  input wire logic [1:0]          clockDividerSelect,
  input wire logic                machineTick,
  input wire logic                moveStart,
  input wire edbs_pkg::edbs_req_s moveReq,
  input wire logic [2:0]          stretchValue,
  input wire logic [10:0]         clockUnit,
  input wire logic                moveBusy,
  input wire logic                moveDone,
  input wire edbs_pkg::edbs_bus_s bus
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_RESET_STATE: assert property (disable iff (1'b0)
    !rst_n |-> stretchValue == 3'h1 && bus.readStrobe_n && !bus.dataOe) else $error("reset state");
  AST_STRETCH_LOAD: assert property (
    stretchWrite |=> stretchValue == $past(stretchSelectField)) else $error("stretch load");
  AST_STRETCH_KEEP: assert property (
    !stretchWrite |=> $stable(stretchValue)) else $error("stretch moved");
  AST_UNIT: assert property (clockUnit == (clockDividerSelect == 2'h3 ? 11'h400 :
    clockDividerSelect == 2'h2 ? 11'h004 : clockMultiplierSelect ? 11'h001 : 11'h002))
    else $error("clock unit");
  AST_WRITE_DATA: assert property (!bus.writeStrobe_n |-> bus.dataOe) else $error("wdata");
  AST_DONE_ONE: assert property (moveDone |=> !moveDone) else $error("done width");
  AST_TICK_PACED: assert property (
    $fell(bus.readStrobe_n) || $fell(bus.writeStrobe_n) |-> $past(machineTick))
    else $error("strobe off tick");
  AST_INT_QUIET: assert property (moveStart && !moveBusy && moveReq.internal |=>
    (bus.readStrobe_n && bus.writeStrobe_n && !bus.dataOe && !bus.addrLatch) [*4])
    else $error("pins moved");
  AST_DONE_IDLE: assert property (
    moveDone |-> bus.readStrobe_n && bus.writeStrobe_n && !bus.addrLatch)
    else $error("strobe at done");
  AST_BUSY_TAKEN: assert property (moveStart && !moveBusy |=> moveBusy) else $error("busy");
  AST_ALE_APART: assert property (
    bus.addrLatch |-> bus.readStrobe_n && bus.writeStrobe_n) else $error("ale overlap");
endmodule

bind edbs_ctrl edbs_ctrl_assertions u_edbs_ctrl_assertions (.*);

// *** tb/edbs_ctrl_tb.sv ***
module edbs_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, rst_n = 1'b1, stretchWrite = 1'b0, moveStart = 1'b0;
  logic clockMultiplierSelect = 1'b0, machineTick = 1'b0, moveBusy, moveDone, doneOe;
  logic [1:0] clockDividerSelect = 2'h0, tickCnt = 2'h0;
  logic [2:0] stretchSelectField = 3'h0, stretchValue;
  logic [7:0] busDataIn, readData;
  logic [10:0] clockUnit, lowCnt, aleCnt, gapCnt, totCnt;
  edbs_pkg::edbs_req_s moveReq = '0;
  edbs_pkg::edbs_bus_s bus;
  int miscompares = 0, compares = 0, cycles = 0;
  edbs_ctrl u_edbs_ctrl (.*);
  edbs_mem_model u_edbs_mem_model (.*);
  initial forever #50 sys_clk = ~sys_clk;
  // ==========================================================
  // helpers
  // ==========================================================
  task automatic stop_test();
    if (miscompares == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    #1;
    tickCnt++;
    machineTick = (tickCnt == 2'h3);
    if (cycles > 5000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic set_stretch(input logic [2:0] s);
    stretchSelectField = s;
    stretchWrite = 1'b1;
    step();
    stretchWrite = 1'b0;
  endtask
  // strobe and latch widths counted in machine ticks
  task automatic move(input logic w, input logic i, input logic [7:0] d);
    moveReq = '{w, i, 24'h000040, d};
    moveStart = 1'b1;
    step();
    moveStart = 1'b0;
    lowCnt = 11'h000;
    aleCnt = 11'h000;
    gapCnt = 11'h000;
    totCnt = 11'h000;
    for (int n = 0; n < 200 && moveDone !== 1'b1; n++) begin
      // sample mid-cycle what the next edge will see
      @(negedge sys_clk);
      lowCnt += 11'((bus.readStrobe_n === 1'b0 || bus.writeStrobe_n === 1'b0) && machineTick);
      aleCnt += 11'(bus.addrLatch === 1'b1 && machineTick);
      gapCnt += 11'(bus.addrLatch === 1'b0 && bus.readStrobe_n === 1'b1 &&
                    bus.writeStrobe_n === 1'b1 && bus.addr === 24'h000040 &&
                    bus.dataOe === w && machineTick === 1'b1);
      totCnt += 11'(machineTick === 1'b1);
      step();
    end
    if (moveDone !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t move did not finish", $time);
    end
    @(negedge sys_clk);
    doneOe = bus.dataOe;
    step();
  endtask
  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic t_unit();
    logic [2:0] sel [4] = '{3'h4, 3'h0, 3'h6, 3'h3};
    logic [10:0] uexp [4] = '{11'h001, 11'h002, 11'h004, 11'h400};
    for (int i = 0; i < 4; i++) begin
      {clockMultiplierSelect, clockDividerSelect} = sel[i];
      step();
      chk(clockUnit, uexp[i]);
    end
  endtask
  task automatic t_sweep();
    logic [10:0] totExp [8] = '{11'h002, 11'h003, 11'h004, 11'h005,
                                11'h009, 11'h00A, 11'h00B, 11'h00C};
    for (int s = 0; s < 8; s++) begin
      set_stretch(3'(s));
      chk(11'(stretchValue), 11'(s));
      move(1'b1, 1'b0, 8'(8'hA0 + s));
      chk(lowCnt, 11'((s == 0 ? 1 : s) + (s >= 4)));
      chk(aleCnt, 11'(1 + (s >= 4)));
      chk(totCnt, totExp[s]);
      chk(gapCnt, 11'((s != 0 ? 1 : 0) + (s >= 4 ? 1 : 0)));
      chk(11'(doneOe), 11'(s != 0 ? 1 : 0));
      move(1'b0, 1'b0, 8'h00);
      chk(11'(readData), 11'(8'hA0 + s));
      chk(lowCnt, 11'((s == 0 ? 1 : s) + (s >= 4)));
      chk(totCnt, totExp[s]);
      chk(gapCnt, 11'((s != 0 ? 1 : 0) + (s >= 4 ? 1 : 0)));
      chk(11'(doneOe), 11'h000);
    end
  endtask
  task automatic t_internal();
    set_stretch(3'h7);
    move(1'b0, 1'b1, 8'h00);
    chk(lowCnt, 11'h000);
    chk(aleCnt, 11'h000);
    chk(totCnt, 11'h002);
  endtask
  task automatic t_mid();
    set_stretch(3'h5);
    fork
      move(1'b1, 1'b0, 8'h5A);
      begin
        repeat (3) step();
        set_stretch(3'h0);
      end
    join
    chk(lowCnt, 11'h006);
    chk(totCnt, 11'h00A);
    chk(11'(stretchValue), 11'h000);
  endtask
  initial begin
    #1 rst_n = 1'b0;
    repeat (6) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    chk(11'(stretchValue), 11'h001);
    t_unit();
    t_sweep();
    t_internal();
    t_mid();
    stop_test();
  end
endmodule
